/* rtl/flash_self_program_pkg.sv */
// Package: register layout, command codes and timing for the flash self-programming controller
`default_nettype none
package flash_self_program_pkg;

	// APB byte addresses of the block's registers
	localparam logic [7:0] addr_ctrl_status = 8'h00;
	localparam logic [7:0] addr_pointer = 8'h04;
	localparam logic [7:0] addr_data_pair = 8'h08;
	localparam logic [7:0] addr_instr = 8'h0C;
	localparam logic [7:0] addr_read_result = 8'h10;
	localparam logic [7:0] addr_page_read = 8'h14;

	// Control register field positions
	localparam int bit_self_prog_enable = 0;
	localparam int bit_page_erase_cmd = 1;
	localparam int bit_page_write_cmd = 2;
	localparam int bit_read_fuse_lock = 3;
	localparam int bit_clear_page_buffer = 4;

	// Accepted five-bit command codes
	localparam logic [4:0] code_clear_buffer = 5'h11;
	localparam logic [4:0] code_read_fuse_lock = 5'h09;
	localparam logic [4:0] code_page_write = 5'h05;
	localparam logic [4:0] code_page_erase = 5'h03;
	localparam logic [4:0] code_buffer_load = 5'h01;

	// Instruction trigger codes written to the instruction register
	localparam logic [1:0] instr_store = 2'h1;
	localparam logic [1:0] instr_load = 2'h2;

	// Fuse/lock pointer values
	localparam logic [15:0] ptr_fuse_low = 16'h0000;
	localparam logic [15:0] ptr_lock = 16'h0001;
	localparam logic [15:0] ptr_fuse_high = 16'h0003;

	// Reset values
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [15:0] word_reset = 16'h0000;
	localparam logic [15:0] erased_word = 16'hFFFF;

	// Arming windows in cycles
	localparam int store_window = 4;
	localparam int load_window = 3;

	// Flash operation timing, timed by the calibrated oscillator (Hz)
	localparam int osc_rate_hz = 9_600_000;
	localparam real flash_op_min_ms = 3.7;
	localparam real flash_op_max_ms = 4.5;
	localparam int flash_op_cycles = int'($ceil(flash_op_min_ms * osc_rate_hz / 1000.0));

	// Page geometry
	localparam int word_bits = 4;
	localparam int page_bits = 5;
	localparam int page_words = 1 << word_bits;

	// Flash operation kinds
	typedef enum {op_idle, op_erase, op_write} flash_op_type;

	// APB request bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} apb_req_type;

endpackage
`default_nettype wire

/* rtl/flash_self_program_control.sv */
// Flash self-programming controller: control register, arming windows, page buffer, flash timing
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module flash_self_program_control
	import flash_self_program_pkg::*;
#(
	parameter int flash_op_count = flash_op_cycles
)
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fuse and lock values, status from the EEPROM controller (pins)
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic lock_bit_first,
	input wire logic lock_bit_second,
	input wire logic eeprom_write_busy,
	// Core stall and flash array strobes
	output logic core_stall,
	output logic flash_erase_strobe,
	output logic flash_write_strobe
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for pin inputs

	logic [7:0] fl_m, fl_s, fh_m, fh_s;
	logic [1:0] lk_m, lk_s;
	logic ee_m, ee_s;

	// Two stages; only the second stage feeds logic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fl_m <= 8'h00; fl_s <= 8'h00;
		end
		else if (clk_en)
		begin
			fl_m <= fuse_low_byte; fl_s <= fl_m;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fh_m <= 8'h00; fh_s <= 8'h00; lk_m <= 2'h0; lk_s <= 2'h0;
			ee_m <= 1'b0; ee_s <= 1'b0;
		end
		else if (clk_en)
		begin
			fh_m <= fuse_high_byte; fh_s <= fh_m;
			lk_m <= {lock_bit_second, lock_bit_first}; lk_s <= lk_m;
			ee_m <= eeprom_write_busy; ee_s <= ee_m;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode

	apb_req_type req;
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	// Access completes in the first access cycle; pready is registered
	logic acc;
	assign acc = req.sel && req.enable && pready && clk_en;
	logic wr_ctrl, wr_ptr, wr_data, wr_instr;
	assign wr_ctrl = acc && req.write && req.addr == addr_ctrl_status;
	assign wr_ptr = acc && req.write && req.addr == addr_pointer;
	assign wr_data = acc && req.write && req.addr == addr_data_pair;
	assign wr_instr = acc && req.write && req.addr == addr_instr;

	////////////////////////////////////////////////////////////////////////
	// Pointer and data register pair

	logic [15:0] pointer;
	logic [15:0] data_pair;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pointer <= word_reset;
			data_pair <= word_reset;
		end
		else if (clk_en)
		begin
			if (wr_ptr)
				pointer <= req.wdata[15:0];
			if (wr_data)
				data_pair <= req.wdata[15:0];
		end
	end

	// Word field sits above the byte select bit, page field above that
	logic [word_bits-1:0] word_in_page_field;
	logic [page_bits-1:0] page_address_field;
	assign word_in_page_field = pointer[word_bits:1];
	assign page_address_field = pointer[word_bits+page_bits:word_bits+1];
	logic byte_select_bit;
	assign byte_select_bit = pointer[0];

	////////////////////////////////////////////////////////////////////////
	// Control register and arming windows

	logic [4:0] ctrl;
	logic [2:0] arm_count;
	flash_op_type op;
	logic [31:0] op_count;
	logic store_go, load_go;
	assign store_go = wr_instr && req.wdata[1:0] == instr_store && ctrl[bit_self_prog_enable]
		&& op == op_idle;
	assign load_go = wr_instr && req.wdata[1:0] == instr_load;

	// Accept only the five codes, never while EEPROM writes or an op runs
	logic code_ok;
	always_comb
	begin
		code_ok = 1'b0;
		if (req.wdata[4:0] == code_clear_buffer || req.wdata[4:0] == code_read_fuse_lock
			|| req.wdata[4:0] == code_page_write || req.wdata[4:0] == code_page_erase
			|| req.wdata[4:0] == code_buffer_load)
			code_ok = !ee_s && op == op_idle;
	end

	logic op_done;
	assign op_done = op != op_idle && op_count == 32'd1;

	// Bits self-clear on use, on window expiry or at operation end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= ctrl_reset[4:0];
			arm_count <= 3'h0;
		end
		else if (clk_en)
		begin
			if (wr_ctrl && code_ok)
			begin
				// Clear-buffer acts at once; nothing stays armed
				ctrl <= (req.wdata[4:0] == code_clear_buffer) ? 5'h00 : req.wdata[4:0];
				arm_count <= 3'(store_window);
			end
			else if (op_done)
				ctrl <= 5'h00;
			else if (op != op_idle)
				ctrl <= ctrl; // Control bits, cleared by the store, held at zero for the whole operation
			else if (store_go || (load_go && ctrl[bit_read_fuse_lock]))
				ctrl <= 5'h00;
			// Read arming closes one count before the store window; a load
			// on that closing edge is still taken by the branch above
			else if (arm_count == 3'h1 || (ctrl[bit_read_fuse_lock]
				&& arm_count == 3'(store_window - load_window + 1)))
			begin
				ctrl <= 5'h00; // Windows of four (store) and three (read)
				arm_count <= 3'h0;
			end
			else if (arm_count != 3'h0)
				arm_count <= arm_count - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash operation timer and core stall

	// Counted at the rate of the calibrated oscillator clock
	// Asynchronous reset also clears the timer: an operation cut off by reset never completes in the array
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op <= op_idle;
			op_count <= 32'd0;
		end
		else if (clk_en)
		begin
			if (op == op_idle && store_go && ctrl[bit_page_erase_cmd])
			begin
				op <= op_erase;
				op_count <= 32'(flash_op_count);
			end
			else if (op == op_idle && store_go && ctrl[bit_page_write_cmd])
			begin
				op <= op_write;
				op_count <= 32'(flash_op_count);
			end
			else if (op_done)
				op <= op_idle;
			else if (op != op_idle)
				op_count <= op_count - 32'd1;
		end
	end

	// Stall and array strobes registered; flash_mem is written only at op_done, so a reset
	// mid-operation clears the timer and the cell write never takes place
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_stall <= 1'b0;
			flash_erase_strobe <= 1'b0;
			flash_write_strobe <= 1'b0;
		end
		else if (clk_en)
		begin
			core_stall <= (op != op_idle && !op_done) || (op == op_idle && store_go
				&& (ctrl[bit_page_erase_cmd] || ctrl[bit_page_write_cmd]));
			flash_erase_strobe <= op == op_idle && store_go && ctrl[bit_page_erase_cmd];
			flash_write_strobe <= op == op_idle && store_go && ctrl[bit_page_write_cmd];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Temporary page buffer and flash array

	logic [15:0] page_buf [page_words];
	logic [page_words-1:0] buf_used;
	logic [15:0] flash_mem [1 << (word_bits + page_bits)];
	logic buf_clear;
	assign buf_clear = (wr_ctrl && code_ok && req.wdata[4:0] == code_clear_buffer)
		|| (op == op_write && op_done);

	// Buffer load ignores byte select; each word writes once between clears
	generate
		for (genvar i = 0; i < page_words; i++)
		begin : g_buf
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					page_buf[i] <= erased_word;
					buf_used[i] <= 1'b0;
				end
				else if (clk_en)
				begin
					if (buf_clear)
					begin
						page_buf[i] <= erased_word;
						buf_used[i] <= 1'b0;
					end
					else if (store_go && ctrl == code_buffer_load && !buf_used[i]
						&& word_in_page_field == word_bits'(i))
					begin
						page_buf[i] <= data_pair;
						buf_used[i] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Array contents change at operation end; data pair plays no part
	logic [page_bits-1:0] op_page;
	always_ff @(posedge pclk)
	begin
		if (clk_en)
		begin
			if (op == op_idle && store_go)
				op_page <= page_address_field;
			if (op_done)
				for (int w = 0; w < page_words; w++)
					flash_mem[{op_page, word_bits'(w)}] <= (op == op_write)
						? (flash_mem[{op_page, word_bits'(w)}] & page_buf[w]) : erased_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Load instruction result and APB read data

	logic [7:0] read_result;
	logic [15:0] fword;
	assign fword = flash_mem[pointer[word_bits+page_bits:1]];

	// Armed read selects lock or fuse by pointer; blocked while EEPROM busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			read_result <= 8'h00;
		else if (clk_en && load_go && op == op_idle)
		begin
			if (ctrl[bit_read_fuse_lock] && !ee_s)
			begin
				if (pointer == ptr_lock)
					read_result <= {6'h00, lk_s};
				else if (pointer == ptr_fuse_high)
					read_result <= fh_s;
				else
					read_result <= fl_s;
			end
			else
				read_result <= byte_select_bit ? fword[15:8] : fword[7:0];
		end
	end

	// Zero-wait-state slave: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready <= req.sel && !req.enable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (req.sel && !req.enable)
			begin
				if (req.addr == addr_ctrl_status)
					prdata <= {27'h0, ctrl};
				else if (req.addr == addr_pointer)
					prdata <= {16'h0000, pointer};
				else if (req.addr == addr_data_pair)
					prdata <= {16'h0000, data_pair};
				else if (req.addr == addr_read_result)
					prdata <= {24'h00_0000, read_result};
				else if (req.addr == addr_page_read)
					prdata <= {16'h0000, fword};
				else if (req.addr != addr_instr)
					pslverr <= 1'b1;
			end
		end
	end

endmodule // flash_self_program_control
`default_nettype wire

/* verification/flash_self_program_monitor.sv */
// Port checker for the flash self-programming controller, with its bind
`default_nettype none
module flash_self_program_monitor
	import flash_self_program_pkg::*;
#(
	parameter int flash_op_count = 20
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status pin and flash side
	input wire logic eeprom_write_busy,
	input wire logic core_stall,
	input wire logic flash_erase_strobe,
	input wire logic flash_write_strobe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	wire logic strobe = flash_erase_strobe | flash_write_strobe; // Any flash op start
	wire logic store_hit = psel & penable & pready & pwrite & (paddr == addr_instr)
		& (pwdata[1:0] == instr_store); // Store instruction taken this edge
	int stall_len; // Cycles the core has been held so far
	// Count stall cycles; a counter because the hold is far beyond a repetition
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stall_len <= 0;
		else
			stall_len <= core_stall ? stall_len + 1 : 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_stall_len;
		$fell(core_stall) |-> stall_len == flash_op_count;
	endproperty
	a_stall_len: assert property (p_stall_len)
		else $error("stall length wrong");
	property p_stall_start;
		$rose(core_stall) |-> strobe;
	endproperty
	a_stall_start: assert property (p_stall_start)
		else $error("stall without flash operation");
	property p_strobe_cause;
		strobe |-> $past(store_hit);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause)
		else $error("flash operation without store");
	property p_strobe_pulse;
		strobe |=> !strobe && core_stall;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse)
		else $error("strobe not a pulse or stall dropped");
	property p_one_op;
		!(flash_erase_strobe && flash_write_strobe);
	endproperty
	a_one_op: assert property (p_one_op)
		else $error("erase and write together");
	property p_ctrl_zero;
		pready && !pwrite && paddr == addr_ctrl_status |-> prdata[31:5] == 27'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("reserved control bits not zero");
	property p_result_byte;
		pready && !pwrite && paddr == addr_read_result |-> prdata[31:8] == 24'h0;
	endproperty
	a_result_byte: assert property (p_result_byte)
		else $error("read result wider than a byte");
	property p_busy_block;
		strobe |-> !$past(eeprom_write_busy, 4);
	endproperty
	a_busy_block: assert property (p_busy_block)
		else $error("flash operation while EEPROM busy");
	c_erase: cover property (flash_erase_strobe);
	c_write: cover property (flash_write_strobe);
	c_err: cover property (pready && pslverr);
endmodule // flash_self_program_monitor
bind flash_self_program_control flash_self_program_monitor #(.flash_op_count(flash_op_count))
	u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.eeprom_write_busy(eeprom_write_busy), .core_stall(core_stall),
	.flash_erase_strobe(flash_erase_strobe), .flash_write_strobe(flash_write_strobe));
`default_nettype wire

/* verification/fuse_source_model.sv */
// Model of the fuse, lock and EEPROM status sources beside the controller
`default_nettype none
module fuse_source_model
(
	// Clock and bench settings
	input wire logic pclk,
	input wire logic [17:0] fuse_set,
	input wire logic busy_set,
	// Pins into the controller
	output logic [7:0] fuse_low_byte,
	output logic [7:0] fuse_high_byte,
	output logic lock_bit_first,
	output logic lock_bit_second,
	output logic eeprom_write_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered drive, as real non-volatile latches would present them
	always @(posedge pclk)
	begin
		fuse_low_byte <= fuse_set[7:0];
		fuse_high_byte <= fuse_set[15:8];
		lock_bit_first <= fuse_set[16];
		lock_bit_second <= fuse_set[17];
		eeprom_write_busy <= busy_set;
	end
endmodule // fuse_source_model
`default_nettype wire

/* verification/flash_self_program_control_tb.sv */
// Self-checking bench for the flash self-programming controller
`default_nettype none
module flash_self_program_control_tb;
	import flash_self_program_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int op_count = 20; // Short flash timing keeps the run brief
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy_set = 0;
	logic [7:0] paddr = 0, flo, fhi;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, core_stall, fes, fws, lb1, lb2, busy;
	logic [17:0] fuse_set = 0; // Fuse and lock values held by the model
	logic [31:0] exp_q[$]; // Expected read data, oldest first
	logic [15:0] d1, d2, d3;
	int fails = 0, n_tests = 0, seed = 11149;
	logic clk_en = 1; // Clock enable, dropped once to check that state freezes
	logic [4:0] bad_codes [5] = '{5'h07, 5'h13, 5'h0B, 5'h15, 5'h1F}; // Refused codes
	always #4 pclk = ~pclk;
	flash_self_program_control #(.flash_op_count(op_count)) u_dut (.pclk(pclk),
		.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fuse_low_byte(flo), .fuse_high_byte(fhi), .lock_bit_first(lb1),
		.lock_bit_second(lb2), .eeprom_write_busy(busy), .core_stall(core_stall),
		.flash_erase_strobe(fes), .flash_write_strobe(fws));
	fuse_source_model u_src (.pclk(pclk), .fuse_set(fuse_set), .busy_set(busy_set),
		.fuse_low_byte(flo), .fuse_high_byte(fhi), .lock_bit_first(lb1),
		.lock_bit_second(lb2), .eeprom_write_busy(busy));
	////////////////////////////////////////////////////////////////////////////////
	task automatic compare_word(input string name, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, e, s);
		end
	endtask
	task automatic compare_bit(input string name, input logic e, input logic s);
		compare_word(name, {31'h0, e}, {31'h0, s});
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One APB transfer; hold keeps psel up for a back-to-back follower
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit hold,
		input logic err);
		int i;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 10 && pready !== 1'b1; i++)
			@(posedge pclk);
		if (i == 10)
		begin
			fails++;
			conclude();
		end
		compare_bit("pslverr", err, pslverr);
		if (!hold)
		begin
			psel <= 0;
			penable <= 0;
			// One idle edge, so a following setup never reassigns psel in this step
			@(posedge pclk);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit hold = 0);
		apb(1, a, d, hold, 0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 0);
		if (!err)
			exp_q.push_back(e);
		apb(0, a, 32'h0000_0000, 0, err);
	endtask
	// Watch for the core hold after a store and wait until it ends
	task automatic wait_stall(input logic stall);
		int i;
		logic seen;
		seen = 0;
		for (i = 0; i < 6 && !seen; i++)
		begin
			@(posedge pclk);
			seen = (core_stall === 1'b1);
		end
		compare_bit("core_stall", stall, seen);
		for (i = 0; i < 60 && core_stall !== 1'b0; i++)
			@(posedge pclk);
		if (i == 60)
			fails++;
	endtask
	// Control code, then its instruction at once, as software must
	task automatic cmd(input logic [4:0] code, input logic [1:0] ins, input logic stall);
		wr(addr_ctrl_status, {27'h0, code}, 1);
		wr(addr_instr, {30'h0, ins});
		wait_stall(stall);
	endtask
	function automatic logic [31:0] ptr(input int pg, input int wd, input bit b);
		return 32'((pg << (word_bits + 1)) | (wd << 1) | b);
	endfunction
	task automatic page_cycle(input int pg);
		wr(addr_pointer, ptr(pg, 0, 0));
		cmd(code_page_erase, instr_store, 1);
		cmd(code_page_write, instr_store, 1);
	endtask
	task automatic load(input int pg, input int wd, input logic [15:0] d);
		wr(addr_pointer, ptr(pg, wd, 1));
		wr(addr_data_pair, {16'h0, d});
		cmd(code_buffer_load, instr_store, 0);
	endtask
	task automatic peek(input int pg, input int wd, input logic [15:0] e);
		wr(addr_pointer, ptr(pg, wd, 0));
		rd(addr_page_read, {16'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read checker: each completed read takes the oldest expectation
	always @(posedge pclk)
	begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
			&& pslverr === 1'b0)
		begin
			if (exp_q.size() == 0)
				compare_word("read count", 32'h0000_0000, 32'h0000_0001);
			else
				compare_word("prdata", exp_q.pop_front(), prdata);
		end
	end
	// Hang guard
	initial
	begin
		repeat (50000) @(posedge pclk);
		fails++;
		conclude();
	end
	initial
	begin
		fuse_set = 18'($random(seed));
		d1 = 16'($random(seed));
		d2 = 16'($random(seed));
		d3 = 16'($random(seed));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(addr_ctrl_status, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000, 1);
		$display("Test reset done");
		for (int k = 0; k < 3; k++)
		begin
			wr(addr_pointer, {16'h0000, k == 0 ? ptr_fuse_low : k == 1 ? ptr_lock : ptr_fuse_high});
			cmd(code_read_fuse_lock, instr_load, 0);
			rd(addr_read_result, k == 1 ? {30'h0, fuse_set[17:16]}
				: {24'h0, k == 0 ? fuse_set[7:0] : fuse_set[15:8]});
			rd(addr_ctrl_status, 32'h0000_0000);
		end
		$display("Test fuse read done");
		load(3, 5, d1);
		load(3, 5, d2);
		load(3, 6, d3);
		page_cycle(3);
		peek(3, 5, d1);
		peek(3, 6, d3);
		peek(3, 7, 16'hFFFF);
		page_cycle(4);
		peek(4, 5, 16'hFFFF);
		$display("Test page write done");
		// Load one cycle past the three-cycle read window returns flash, not fuse
		wr(addr_pointer, ptr(3, 5, 0));
		wr(addr_ctrl_status, {27'h0, code_read_fuse_lock});
		@(posedge pclk);
		wr(addr_instr, {30'h0, instr_load});
		rd(addr_read_result, {24'h0, d1[7:0]});
		$display("Test read window done");
		load(4, 5, d3);
		wr(addr_ctrl_status, {27'h0, code_clear_buffer});
		rd(addr_ctrl_status, 32'h0000_0000);
		page_cycle(4);
		peek(4, 5, 16'hFFFF);
		$display("Test clear buffer done");
		foreach (bad_codes[k])
			cmd(bad_codes[k], instr_store, 0);
		$display("Test bad codes done");
		wr(addr_ctrl_status, {27'h0, code_page_erase});
		repeat (6) @(posedge pclk);
		rd(addr_ctrl_status, 32'h0000_0000);
		wr(addr_instr, {30'h0, instr_store});
		wait_stall(0);
		$display("Test window expiry done");
		// Arming window must not run down while the clock enable is low
		wr(addr_ctrl_status, {27'h0, code_page_erase});
		clk_en <= 0;
		repeat (8) @(posedge pclk);
		clk_en <= 1;
		wr(addr_instr, {30'h0, instr_store});
		wait_stall(1);
		$display("Test clock enable done");
		busy_set <= 1;
		repeat (5) @(posedge pclk);
		cmd(code_page_erase, instr_store, 0);
		wr(addr_ctrl_status, {27'h0, code_read_fuse_lock});
		rd(addr_ctrl_status, 32'h0000_0000);
		busy_set <= 0;
		repeat (5) @(posedge pclk);
		$display("Test EEPROM busy done");
		conclude();
	end
endmodule // flash_self_program_control_tb
`default_nettype wire
